// ### core/hs_timer_ctrl.sv
/*
  hot-swap fault timer and current-limit reference control.
  assumes comparator flags arrive asynchronously from the analog front end
  and register writes come from the transport logic on clk_in.
*/
module hs_timer_ctrl
  import hs_timer_pkg::*;
#(
  parameter int unsigned INIT_CYC = INIT_MIN_CYC,
  parameter int unsigned RETRY_CYC = RETRY_CYC_DEF
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire flags_s flags_in,
  input wire logic [REF_W-1:0] current_limit_set_in,
  input wire logic [REF_W-1:0] power_limit_set_in,
  input wire logic [REF_W-1:0] startup_limit_pin_in,
  input wire logic operation_on_in,
  input wire logic reg_wr_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [FRAC_W-1:0] reg_wdata_in,
  output logic [FRAC_W-1:0] reg_rdata_out,
  output tsrc_s timer_src_out,
  output logic gate_shutdown_out,
  output logic fault_out,
  output logic power_good_out,
  output logic [REF_W-1:0] limit_ref_out
);
  typedef enum logic [7:0] {
    ST_RESET = 8'h01, ST_INIT_UP = 8'h02, ST_INIT_DN = 8'h04,
    ST_WAIT = 8'h08, ST_ON = 8'h10, ST_TRIP = 8'h20,
    ST_LATCH = 8'h40, ST_RETRY = 8'h80
  } state_e;

  logic rst_s1_q, rst_q;
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rst_s1_q <= 1'b0;
      rst_q <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_q <= rst_s1_q;
    end
  end
  wire logic rstn = rst_q;

  // two-stage synchroniser for comparator flags
  flags_s f1_q, f_q;
  always_ff @(posedge clk_in or negedge rstn) begin
    if (!rstn) begin
      f1_q <= '0;
      f_q <= '0;
    end else begin
      f1_q <= flags_in;
      f_q <= f1_q;
    end
  end

  // write strobe already runs on clk_in, so it is taken without a synchroniser
  logic [FRAC_W-1:0] frac_q, frac_d;
  always_comb begin
    frac_d = frac_q;
    if (reg_wr_in && reg_addr_in == FRACTION_ADDR) frac_d = reg_wdata_in;
  end

  function automatic logic [REF_W-1:0] min2(input logic [REF_W-1:0] a,
                                             input logic [REF_W-1:0] b);
    return (a < b) ? a : b;
  endfunction

  function automatic logic [REF_W-1:0] floor_ref(
    input logic [REF_W-1:0] a);
    return (a < REF_FLOOR_MV) ? REF_FLOOR_MV : a;
  endfunction

  logic [REF_W+FRAC_W:0] prod;
  logic [REF_W-1:0] reg_ref, start_ref, ref_d;
  always_comb begin
    prod = current_limit_set_in * ({1'b0, frac_q} + 5'h01);
    reg_ref = prod[REF_W+FRAC_DIV_SH-1:FRAC_DIV_SH];
    start_ref = min2(startup_limit_pin_in, reg_ref);
    ref_d = min2(current_limit_set_in, power_limit_set_in);
    if (!power_good_out) ref_d = min2(ref_d, start_ref);
    ref_d = floor_ref(ref_d);
  end

  state_e st_q, st_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic init_done_q, init_done_d, uv_prev_q, on_prev_q;
  logic rearm_q, rearm_d;
  tsrc_s src_d;
  logic gate_d, fault_d, pg_d;
  wire logic window_ok = f_q.undervoltage_in && !f_q.overvoltage_in;

  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    init_done_d = init_done_q;
    rearm_d = rearm_q;
    src_d = SRC_HOLD;
    gate_d = 1'b1;
    fault_d = fault_out;
    pg_d = 1'b0;
    // edges are taken in any state; latch-off drops those seen too early
    if (!uv_prev_q && f_q.undervoltage_in) rearm_d = 1'b1;
    if (!on_prev_q && operation_on_in) rearm_d = 1'b1;
    if (f_q.supply_lockout) begin
      st_d = ST_RESET;
      cnt_d = '0;
      fault_d = 1'b0;
    end else begin
      unique case (st_q)
        ST_RESET: begin
          st_d = ST_INIT_UP;
          // a lockout mid-run must restart the whole minimum interval
          init_done_d = 1'b0;
          cnt_d = '0;
        end
        ST_INIT_UP: begin
          src_d = '{pu_small: 1'b1, default: 1'b0};
          if (!init_done_q) cnt_d = cnt_q + 1'b1;
          if (cnt_q >= CNT_W'(INIT_CYC - 1)) init_done_d = 1'b1;
          if (init_done_q && f_q.timer_high_threshold)
            st_d = ST_INIT_DN;
        end
        ST_INIT_DN: begin
          src_d = SRC_HOLD;
          if (f_q.timer_low_threshold) st_d = ST_WAIT;
        end
        ST_WAIT: begin
          src_d = '{pd_weak: 1'b1, default: 1'b0};
          if (window_ok) st_d = ST_ON;
        end
        ST_ON: begin
          src_d = '{pd_weak: 1'b1, default: 1'b0};
          gate_d = 1'b0;
          pg_d = f_q.power_good;
          if (!window_ok) st_d = ST_WAIT;
          else if (f_q.breaker_trip_level) st_d = ST_TRIP;
        end
        ST_TRIP: begin
          src_d = '{pu_large: 1'b1, default: 1'b0};
          gate_d = 1'b0;
          pg_d = f_q.power_good;
          if (f_q.timer_high_threshold) begin
            src_d = '{pd_weak: 1'b1, default: 1'b0};
            gate_d = 1'b1;
            fault_d = 1'b1;
            pg_d = 1'b0;
            rearm_d = 1'b0;
            cnt_d = '0;
            st_d = f_q.retry_n ? ST_LATCH : ST_RETRY;
          end else if (!f_q.breaker_trip_level) begin
            st_d = ST_ON;
          end
        end
        ST_LATCH: begin
          src_d = '{pd_weak: 1'b1, default: 1'b0};
          if (!f_q.timer_low_threshold) rearm_d = 1'b0;
          else if (rearm_q) begin
            fault_d = 1'b0;
            st_d = ST_WAIT;
          end
        end
        ST_RETRY: begin
          src_d = '{pd_weak: 1'b1, default: 1'b0};
          cnt_d = cnt_q + 1'b1;
          if (cnt_q >= CNT_W'(RETRY_CYC - 1) && f_q.timer_low_threshold) begin
            fault_d = 1'b0;
            st_d = ST_WAIT;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rstn) begin
    if (!rstn) begin
      st_q <= ST_RESET;
      cnt_q <= '0;
      init_done_q <= 1'b0;
      rearm_q <= 1'b0;
      uv_prev_q <= 1'b0;
      on_prev_q <= 1'b0;
      frac_q <= FRAC_RESET;
      timer_src_out <= SRC_HOLD;
      gate_shutdown_out <= 1'b1;
      fault_out <= 1'b0;
      power_good_out <= 1'b0;
      limit_ref_out <= REF_FLOOR_MV;
      reg_rdata_out <= '0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      init_done_q <= init_done_d;
      rearm_q <= rearm_d;
      uv_prev_q <= f_q.undervoltage_in;
      on_prev_q <= operation_on_in;
      frac_q <= frac_d;
      timer_src_out <= src_d;
      gate_shutdown_out <= gate_d;
      fault_out <= fault_d;
      power_good_out <= pg_d;
      limit_ref_out <= ref_d;
      reg_rdata_out <= frac_q;
    end
  end

  // run length of the small pull-up; read only by the minimum-time check
  logic [CNT_W-1:0] pu_run_q, pu_run_d;
  always_comb begin
    pu_run_d = timer_src_out.pu_small ? pu_run_q + 1'b1 : '0;
  end
  always_ff @(posedge clk_in or negedge rstn) begin
    if (!rstn) begin
      pu_run_q <= '0;
    end else begin
      pu_run_q <= pu_run_d;
    end
  end

  property p_one_src;
    @(posedge clk_in) disable iff (!rstn) $onehot(timer_src_out);
  endproperty
  a_one_src: assert property (p_one_src)
    else $error("timer sources");

  property p_floor;
    @(posedge clk_in) disable iff (!rstn) limit_ref_out >= REF_FLOOR_MV;
  endproperty
  a_floor: assert property (p_floor)
    else $error("ref below floor");

  property p_pg_start;
    @(posedge clk_in) disable iff (!rstn)
      power_good_out |=> limit_ref_out == floor_ref(
        min2($past(current_limit_set_in), $past(power_limit_set_in)));
  endproperty
  a_pg_start: assert property (p_pg_start)
    else $error("start-up limit still applied");

  property p_lockout;
    @(posedge clk_in) disable iff (!rstn)
      f_q.supply_lockout |=> gate_shutdown_out && timer_src_out.pd_strong;
  endproperty
  a_lockout: assert property (p_lockout)
    else $error("lockout hold");

  property p_trip_src;
    @(posedge clk_in) disable iff (!rstn)
      st_q == ST_TRIP && !f_q.timer_high_threshold && !f_q.supply_lockout
      |=> timer_src_out.pu_large;
  endproperty
  a_trip_src: assert property (p_trip_src)
    else $error("no large pu");

  property p_fault;
    @(posedge clk_in) disable iff (!rstn)
      st_q == ST_TRIP && f_q.timer_high_threshold && !f_q.supply_lockout
      |=> fault_out && gate_shutdown_out && !power_good_out;
  endproperty
  a_fault: assert property (p_fault)
    else $error("fault action");

  property p_init_min;
    @(posedge clk_in) disable iff (!rstn)
      $fell(timer_src_out.pu_small) && !$past(f_q.supply_lockout)
      |-> pu_run_q >= CNT_W'(INIT_CYC);
  endproperty
  a_init_min: assert property (p_init_min)
    else $error("init short");

  property p_latch_hold;
    @(posedge clk_in) disable iff (!rstn)
      st_q == ST_LATCH && !f_q.timer_low_threshold |=> st_q != ST_WAIT;
  endproperty
  a_latch_hold: assert property (p_latch_hold)
    else $error("early restart");

  property p_frac_reset;
    @(posedge clk_in) $rose(rstn) |-> frac_q == FRAC_RESET;
  endproperty
  a_frac_reset: assert property (p_frac_reset)
    else $error("frac reset");

  c_trip: cover property (@(posedge clk_in) st_q == ST_TRIP ##1 st_q == ST_ON);
  c_latch: cover property (@(posedge clk_in) st_q == ST_LATCH);
  c_on: cover property (@(posedge clk_in) st_q == ST_ON && power_good_out);
  c_retry: cover property (@(posedge clk_in)
    st_q == ST_RETRY ##1 st_q == ST_WAIT);
  c_lockout: cover property (@(posedge clk_in)
    f_q.supply_lockout ##1 st_q == ST_RESET);
endmodule

// ### core/hs_timer_pkg.sv
/*
  package for the hot-swap fault timer control block: register offset,
  field widths and reset values, timing counts and reference codes.
  assumes a single 200 MHz system clock.
*/
package hs_timer_pkg;
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned INIT_MIN_MS = 29;
  localparam int unsigned INIT_MIN_CYC = INIT_MIN_MS * (CLK_HZ / 1000);
  localparam int unsigned RETRY_S = 10;
  localparam int unsigned RETRY_CYC_DEF = RETRY_S * CLK_HZ;
  localparam logic [7:0] FRACTION_ADDR = 8'hf6;
  localparam int FRAC_W = 4;
  localparam logic [FRAC_W-1:0] FRAC_RESET = 4'hf;
  localparam int REF_W = 12;
  // references are codes in millivolts at the comparator input
  localparam logic [REF_W-1:0] REF_FLOOR_MV = 12'h064; // 100 mV
  localparam int FRAC_DIV_SH = 4;                       // divide by 16
  localparam int CNT_W = 32;

  typedef struct packed {
    logic timer_high_threshold;
    logic timer_low_threshold;
    logic breaker_trip_level;
    logic undervoltage_in;
    logic overvoltage_in;
    logic power_good;
    logic supply_lockout;
    logic retry_n;
  } flags_s;

  typedef struct packed {
    logic pu_small;
    logic pu_large;
    logic pd_weak;
    logic pd_strong;
  } tsrc_s;

  localparam tsrc_s SRC_HOLD = '{pu_small: 1'b0, pu_large: 1'b0,
                                 pd_weak: 1'b0, pd_strong: 1'b1};
endpackage

// ### core/unused_placeholder_none.sv
/*
  intentionally empty compile unit; holds no logic.
  assumes nothing.
*/

// ### testbench/hs_timer_cap.sv
/*
  behavioural timer capacitor for the fault timer bench.
  assumes one-hot source selects and comparators at 1000 and 200 mV.
*/
module hs_timer_cap
  import hs_timer_pkg::*;
(
  input wire logic clk_in,
  input wire tsrc_s src_in,
  output logic high_out,
  output logic low_out
);
  timeunit 1ns;
  timeprecision 1ps;
  int v_mv = 0;
  // slopes keep the source order but are scaled so each phase is short
  always @(posedge clk_in) begin
    if (src_in.pu_small && v_mv < 2700) v_mv <= v_mv + 30;
    if (src_in.pu_large && v_mv < 2700) v_mv <= v_mv + 60;
    if (src_in.pd_weak) v_mv <= (v_mv > 2) ? v_mv - 2 : 0;
    if (src_in.pd_strong) v_mv <= (v_mv > 100) ? v_mv - 100 : 0;
  end
  assign high_out = v_mv >= 1000;
  assign low_out = v_mv < 200;
endmodule

// ### testbench/tb_hs_timer_ctrl.sv
/*
  self-checking bench for hs_timer_ctrl and a behavioural timer capacitor.
  assumes registered outputs and a two-flop sync on the flag inputs.
*/
module tb_hs_timer_ctrl
  import hs_timer_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned INIT_T = 100;
  // longer than the capacitor discharge, so the counter sets the delay
  localparam int unsigned RETRY_T = 800;
  logic clk_in = 1'b0;
  logic rstn_in = 1'b0;
  flags_s drv = 8'h01;
  flags_s f;
  logic [REF_W-1:0] current_limit_set = 12'h3e8, power_limit_set = 12'h3e8, pin = 12'h3e8, lref;
  logic wr = 1'b0, on_bit = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [FRAC_W-1:0] wdata = 4'h0, frac = FRAC_RESET, rdata;
  tsrc_s src;
  logic gate_off, fault, pg, hi, lo;
  int errors = 0, total_checks = 0, seed = 32'h3692, n;
  always_comb begin
    f = drv;
    f.timer_high_threshold = hi;
    f.timer_low_threshold = lo;
  end
  hs_timer_ctrl #(.INIT_CYC(INIT_T), .RETRY_CYC(RETRY_T)) u_hs_timer_ctrl (
    .clk_in(clk_in), .rstn_in(rstn_in), .flags_in(f),
    .current_limit_set_in(current_limit_set), .power_limit_set_in(power_limit_set),
    .startup_limit_pin_in(pin), .operation_on_in(on_bit), .reg_wr_in(wr),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
    .timer_src_out(src), .gate_shutdown_out(gate_off), .fault_out(fault),
    .power_good_out(pg), .limit_ref_out(lref));
  hs_timer_cap u_hs_timer_cap (.clk_in(clk_in), .src_in(src),
    .high_out(hi), .low_out(lo));
  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input logic [REF_W-1:0] seen,
                       input logic [REF_W-1:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  function automatic logic cond(input int k);
    case (k)
      0: return src.pu_large;
      1: return src.pd_weak;
      2: return fault;
      3: return !gate_off;
      4: return src.pd_strong;
      default: return src.pu_small;
    endcase
  endfunction
  task automatic wait_on(input int k, input int lim, output int c);
    c = 0;
    #1;
    while (cond(k) !== 1'b1) begin
      @(posedge clk_in);
      #1;
      c++;
      if (c > lim) begin
        errors++;
        $display("unexpected at %0t: wait %0d ran out", $time, k);
        close_out();
      end
    end
  endtask
  // start-up fraction applies only while power good is low; floor last
  function automatic logic [REF_W-1:0] exp_ref(input logic pg_on);
    int r;
    int s;
    r = (current_limit_set < power_limit_set) ? current_limit_set : power_limit_set;
    s = (int'(current_limit_set) * (int'(frac) + 1)) >> 4;
    if (!pg_on && pin < r) r = pin;
    if (!pg_on && s < r) r = s;
    if (r < 100) r = 100;
    return REF_W'(r);
  endfunction
  initial begin
    forever #2.5 clk_in = ~clk_in;
  end
  initial begin
    logic [FRAC_W-1:0] w;
    logic [7:0] a;
    repeat (3) @(posedge clk_in);
    #1 check(src, SRC_HOLD);
    check(gate_off, 1'b1);
    @(posedge clk_in) rstn_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    #1 check(rdata, FRAC_RESET);
    wait_on(5, 20, n);
    wait_on(4, 1000, n);
    check(n >= INIT_T, 1'b1);
    wait_on(1, 100, n);
    check(lo, 1'b1);
    repeat (20) @(posedge clk_in);
    drv.overvoltage_in <= 1'b1;
    repeat (20) @(posedge clk_in);
    #1 check(gate_off, 1'b1);
    @(posedge clk_in) drv.undervoltage_in <= 1'b1;
    repeat (20) @(posedge clk_in);
    #1 check(gate_off, 1'b1);
    @(posedge clk_in) drv.overvoltage_in <= 1'b0;
    wait_on(3, 20, n);
    for (int i = 0; i < 16; i++) begin
      w = (i == 0) ? 4'h0 : FRAC_W'($random(seed));
      a = (i == 3) ? 8'hf5 : FRACTION_ADDR;
      if (a == FRACTION_ADDR) frac = w;
      @(posedge clk_in);
      current_limit_set <= (i == 0) ? 12'h050 : REF_W'($random(seed));
      power_limit_set <= REF_W'($random(seed));
      pin <= REF_W'($random(seed));
      wr <= 1'b1;
      addr <= a;
      wdata <= w;
      drv.power_good <= i[0];
      @(posedge clk_in) wr <= 1'b0;
      repeat (5) @(posedge clk_in);
      #1 check(rdata, frac);
      check(pg, i[0]);
      check(lref, exp_ref(i[0]));
    end
    @(posedge clk_in) drv.breaker_trip_level <= 1'b1;
    wait_on(0, 6, n);
    check(gate_off, 1'b0);
    repeat (3) @(posedge clk_in);
    drv.breaker_trip_level <= 1'b0;
    wait_on(1, 6, n);
    check(fault, 1'b0);
    @(posedge clk_in) drv.breaker_trip_level <= 1'b1;
    wait_on(2, 60, n);
    check(gate_off, 1'b1);
    check(pg, 1'b0);
    check(src.pd_weak, 1'b1);
    @(posedge clk_in) drv.undervoltage_in <= 1'b0;
    drv.breaker_trip_level <= 1'b0;
    repeat (4) @(posedge clk_in);
    drv.undervoltage_in <= 1'b1;
    repeat (600) @(posedge clk_in);
    #1 check(gate_off, 1'b1);
    @(posedge clk_in) drv.undervoltage_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    drv.undervoltage_in <= 1'b1;
    wait_on(3, 400, n);
    check(fault, 1'b0);
    @(posedge clk_in) drv.retry_n <= 1'b0;
    drv.breaker_trip_level <= 1'b1;
    wait_on(2, 60, n);
    @(posedge clk_in) drv.breaker_trip_level <= 1'b0;
    wait_on(3, 2000, n);
    check(n >= RETRY_T, 1'b1);
    check(n <= RETRY_T + 8, 1'b1);
    @(posedge clk_in) drv.retry_n <= 1'b1;
    drv.breaker_trip_level <= 1'b1;
    wait_on(2, 60, n);
    @(posedge clk_in) drv.breaker_trip_level <= 1'b0;
    on_bit <= 1'b0;
    repeat (4) @(posedge clk_in);
    on_bit <= 1'b1;
    repeat (600) @(posedge clk_in);
    #1 check(gate_off, 1'b1);
    @(posedge clk_in) on_bit <= 1'b0;
    repeat (4) @(posedge clk_in);
    on_bit <= 1'b1;
    wait_on(3, 400, n);
    check(fault, 1'b0);
    @(posedge clk_in) drv.supply_lockout <= 1'b1;
    wait_on(4, 6, n);
    check(gate_off, 1'b1);
    @(posedge clk_in) drv.supply_lockout <= 1'b0;
    wait_on(5, 6, n);
    wait_on(4, 1000, n);
    check(n >= INIT_T, 1'b1);
    close_out();
  end
endmodule
